/* File: core/rcw_pkg.sv */
// Package for the reset and watchdog block: register map, fields, timing counts
package rcw_pkg;
  // Register byte addresses (Wishbone, one word each)
  localparam logic [7:0] RCW_MISC_ADDR   = 8'h0c; // Miscellaneous control/status
  localparam logic [7:0] RCW_IRQ_ST_ADDR = 8'h10; // Interrupt status
  localparam logic [7:0] RCW_IRQ_MK_ADDR = 8'h14; // Interrupt mask
  localparam logic [7:0] RCW_VEC_ADDR    = 8'h18; // Reset vector and cause
  // Field positions in the miscellaneous register
  localparam int RCW_POR_BIT  = 7;                // Power-on flag
  localparam int RCW_WATCHDOG_ENABLE_KICK_BIT = 0;                // Watchdog enable/kick
  localparam logic [7:0] RCW_MISC_MASK = 8'h81;   // Implemented bits
  // Interrupt status bits
  localparam int RCW_EV_POR  = 0;                 // Power-on reset seen
  localparam int RCW_EV_EXT  = 1;                 // External reset seen
  localparam int RCW_EV_WATCHDOG_ENABLE_KICK = 2;                 // Watchdog reset seen
  localparam logic [2:0] RCW_EV_MASK_RST = 3'h0;  // Mask reset value
  // Reset vector
  localparam logic [15:0] RCW_VEC_LO = 16'h1ffe;  // Vector low byte address
  localparam logic [15:0] RCW_VEC_HI = 16'h1fff;  // Vector high byte address
  // Timing (machine cycles)
  localparam int RCW_POR_SHORT = 16;              // Short power-on delay
  localparam int RCW_POR_LONG  = 4064;            // Long power-on delay
  localparam int RCW_PRE4      = 4;               // First watchdog prescaler
  localparam int RCW_PRE256    = 256;             // Second watchdog prescaler
  localparam logic [2:0] RCW_WD_FINAL = 3'h7;     // Watchdog final state
  localparam int RCW_DOG_PULSE_NS = 120;          // Minimum watchdog pulse, ns
  localparam int RCW_CLK_NS       = 40;           // Machine cycle, ns
  localparam logic [3:0] RCW_DOG_PULSE_CYC =
    4'((RCW_DOG_PULSE_NS + RCW_CLK_NS - 1) / RCW_CLK_NS); // Round up
  // Carrier for the reset controller state
  typedef enum logic [1:0] {
    RCW_ST_POR  = 2'b00,                          // Power-on delay
    RCW_ST_WAIT = 2'b01,                          // Waiting for pin high
    RCW_ST_RUN  = 2'b11,                          // Running
    RCW_ST_DOG  = 2'b10                           // Driving watchdog pulse
  } rcw_state_e;
  typedef struct packed {
    logic [1:0]  cause;                           // 0 por,1 ext,2 watchdog_enable_kick
    logic        core_rst;                        // Core held in reset
    logic        pin_drive;                       // Pull pin low
  } rcw_rst_s;
endpackage : rcw_pkg

/* File: core/rcw_top.sv */
// Reset generation and operating-check watchdog with a Wishbone register port
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rcw_top #(
  parameter int unsigned POR_LONG_CYC = rcw_pkg::RCW_POR_LONG, // Long delay count
  parameter bit          POR_LONG_SEL = 1'b1,                   // Option: long delay
  parameter bit          WATCHDOG_ENABLE_KICK_AUTO    = 1'b0                    // Option: auto enable
) (
  input  wire logic        clk_i,        // Machine clock 25 MHz
  input  wire logic        rst_i,        // Supply-rise detector, sync high
  input  wire logic        osc_ok_i,     // Oscillator active
  input  wire logic        pin_rst_n_i,  // Reset pin level, low active
  output logic             pin_rst_o,    // Pin output value (always 0)
  output logic             pin_rst_oe_n_o, // Pin drive, low = pulling
  input  wire logic        tmr_carry7_i, // Timer bit 7 carry pulse
  output logic             core_rst_o,   // Core reset, high active
  output logic             imask_set_o,  // Set interrupt mask bit
  output logic [15:0]      vec_addr_o,   // Vector fetch address
  output logic             irq_o,        // Level interrupt
  input  wire logic        wb_cyc_i,     // Wishbone cycle
  input  wire logic        wb_stb_i,     // Wishbone strobe
  input  wire logic        wb_we_i,      // Wishbone write
  input  wire logic [7:0]  wb_adr_i,     // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,     // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,     // Wishbone write data
  output logic [31:0]      wb_dat_o,     // Wishbone read data
  output logic             wb_ack_o      // Wishbone acknowledge
);
  import rcw_pkg::*;

  localparam logic [12:0] POR_CYC =
    POR_LONG_SEL ? 13'(POR_LONG_CYC) : 13'(RCW_POR_SHORT); // Chosen delay

  // Wrapped 8-bit field write helper
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
             && (wb_adr_i == a);
  endfunction : wr_hit

  // Synchroniser stages for the pin
  logic        sync1_reg, sync1_next;  // First stage, read only by second
  logic        sync2_reg, sync2_next;  // Usable pin level
  // Reset controller state
  rcw_state_e  st_reg, st_next;        // Controller state
  logic [12:0] cnt_reg, cnt_next;      // Power-on and pulse counter
  rcw_rst_s    rs_reg, rs_next;        // Reset outputs bundle
  logic        imask_reg, imask_next;  // Mask-set pulse at release
  // Watchdog
  logic [1:0]  pre4_reg, pre4_next;    // Divide by 4
  logic [7:0]  pre256_reg, pre256_next; // Divide by 256
  logic [2:0]  wdc_reg, wdc_next;      // Step counter, fires at 7
  logic        wden_reg, wden_next;    // Watchdog enabled
  logic        wdfire;                 // Timeout this cycle
  // Registers
  logic        porf_reg, porf_next;    // Power-on flag
  logic [2:0]  ist_reg, ist_next;      // Sticky event status
  logic [2:0]  imk_reg, imk_next;      // Event mask
  logic        irq_reg, irq_next;      // Interrupt output
  logic        ack_reg, ack_next;      // Bus acknowledge
  logic [31:0] dat_reg, dat_next;      // Bus read data
  logic [2:0]  ev;                     // Event pulses

  // Pin synchroniser next values
  always_comb begin
    sync1_next = pin_rst_n_i;
    sync2_next = sync1_reg;
  end

  // Reset sequencing: the pin is re-read through the synchroniser, so any low
  // level sampled at a clock edge reaches the state machine two cycles later
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    rs_next    = rs_reg;
    imask_next = 1'b0;
    ev         = 3'h0;
    unique case (st_reg)
      RCW_ST_POR: begin
        rs_next.pin_drive = 1'b1;
        rs_next.core_rst  = 1'b1;
        if (osc_ok_i) begin            // Count from oscillator start
          if (cnt_reg >= POR_CYC - 13'h1) begin
            rs_next.pin_drive = 1'b0;
            st_next  = RCW_ST_WAIT;
            cnt_next = 13'h0;
          end else begin
            cnt_next = cnt_reg + 13'h1;
          end
        end
      end
      RCW_ST_WAIT: begin
        rs_next.pin_drive = 1'b0;
        // Pin may still be held low by outside circuitry
        if (sync2_reg) begin
          st_next          = RCW_ST_RUN;
          rs_next.core_rst = 1'b0;
          imask_next       = 1'b1;
        end
      end
      RCW_ST_RUN: begin
        if (wdfire) begin
          st_next           = RCW_ST_DOG;
          cnt_next          = 13'h0;
          rs_next.core_rst  = 1'b1;
          rs_next.pin_drive = 1'b1;
          rs_next.cause     = 2'd2;
          ev[RCW_EV_WATCHDOG_ENABLE_KICK]   = 1'b1;
        end else if (!sync2_reg) begin // External reset, on far side
          st_next          = RCW_ST_WAIT;
          rs_next.core_rst = 1'b1;
          rs_next.cause    = 2'd1;
          ev[RCW_EV_EXT]   = 1'b1;
        end
      end
      RCW_ST_DOG: begin
        // Count only while the pin is really seen low
        if (!sync2_reg) begin
          if (cnt_reg >= 13'(RCW_DOG_PULSE_CYC) - 13'h1) begin
            rs_next.pin_drive = 1'b0;
            st_next = RCW_ST_WAIT;
          end else begin
            cnt_next = cnt_reg + 13'h1;
          end
        end
      end
      default: begin
        st_next = RCW_ST_POR;
      end
    endcase
  end

  // Watchdog chain: prescalers always run on timer carries
  always_comb begin
    pre4_next   = pre4_reg;
    pre256_next = pre256_reg;
    wdc_next    = wdc_reg;
    wden_next   = wden_reg;
    wdfire      = 1'b0;
    if (tmr_carry7_i) begin
      pre4_next = pre4_reg + 2'h1;
      if (pre4_reg == 2'(RCW_PRE4 - 1)) begin
        pre256_next = pre256_reg + 8'h1;
        if (pre256_reg == 8'(RCW_PRE256 - 1) && wden_reg) begin
          wdc_next = wdc_reg + 3'h1;
        end
      end
    end
    if (wden_reg && wdc_reg == RCW_WD_FINAL && st_reg == RCW_ST_RUN) begin
      wdfire = 1'b1;
    end
    if (wr_hit(RCW_MISC_ADDR) && wb_dat_i[RCW_WATCHDOG_ENABLE_KICK_BIT]) begin
      wden_next = 1'b1;                // zero is ignored
      wdc_next  = 3'h0;
    end
    if (rs_reg.core_rst) begin
      wdc_next  = 3'h0;
      wden_next = WATCHDOG_ENABLE_KICK_AUTO;
    end
  end

  // Register file and interrupt logic
  always_comb begin
    porf_next = porf_reg;
    ist_next  = ist_reg;
    imk_next  = imk_reg;
    ack_next  = 1'b0;
    dat_next  = dat_reg;
    if (wr_hit(RCW_MISC_ADDR) && !wb_dat_i[RCW_POR_BIT]) begin
      porf_next = 1'b0;                // software cannot set it
    end
    if (wr_hit(RCW_IRQ_ST_ADDR)) begin
      ist_next = ist_reg & ~wb_dat_i[2:0];
    end
    if (wr_hit(RCW_IRQ_MK_ADDR)) begin
      imk_next = wb_dat_i[2:0];
    end
    ist_next = ist_next | ev;          // Set wins over clear
    if (st_reg == RCW_ST_POR) begin
      porf_next = 1'b1;
      ist_next[RCW_EV_POR] = 1'b1;
    end
    irq_next = |(ist_next & imk_next);
    if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      ack_next = 1'b1;
      unique case (wb_adr_i)
        RCW_MISC_ADDR:   dat_next = {24'h0, porf_reg, 6'h0, wden_reg};
        RCW_IRQ_ST_ADDR: dat_next = {29'h0, ist_reg};
        RCW_IRQ_MK_ADDR: dat_next = {29'h0, imk_reg};
        RCW_VEC_ADDR:    dat_next = {14'h0, rs_reg.cause, RCW_VEC_LO};
        default:         dat_next = 32'h0;   // Unmapped reads zero
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
    if (rst_i) begin
      st_reg     <= RCW_ST_POR;
      cnt_reg    <= 13'h0;
      rs_reg     <= '{cause: 2'd0, core_rst: 1'b1, pin_drive: 1'b1};
      imask_reg  <= 1'b0;
      pre4_reg   <= 2'h0;
      pre256_reg <= 8'h0;
      wdc_reg    <= 3'h0;
      wden_reg   <= 1'b0;
      porf_reg   <= 1'b1;
      ist_reg    <= 3'h0;
      imk_reg    <= RCW_EV_MASK_RST;
      irq_reg    <= 1'b0;
      ack_reg    <= 1'b0;
      dat_reg    <= 32'h0;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      rs_reg     <= rs_next;
      imask_reg  <= imask_next;
      pre4_reg   <= pre4_next;
      pre256_reg <= pre256_next;
      wdc_reg    <= wdc_next;
      wden_reg   <= wden_next;
      porf_reg   <= porf_next;
      ist_reg    <= ist_next;
      imk_reg    <= imk_next;
      irq_reg    <= irq_next;
      ack_reg    <= ack_next;
      dat_reg    <= dat_next;
    end
  end

  // Outputs straight from flops, except the constant pin value and vector address
  assign pin_rst_o      = 1'b0;        // Open drain: only ever pulls low
  assign pin_rst_oe_n_o = ~rs_reg.pin_drive;
  assign core_rst_o     = rs_reg.core_rst;
  assign imask_set_o    = imask_reg;
  assign vec_addr_o     = RCW_VEC_LO;
  assign irq_o          = irq_reg;
  assign wb_ack_o       = ack_reg;
  assign wb_dat_o       = dat_reg;

  // Pin pulled for the whole power-on delay
  por_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_POR && $past(st_reg) == RCW_ST_POR |-> !pin_rst_oe_n_o)
    else $error("pin not driven in power-on");
  // Core stays in reset while the pin is seen low
  hold_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_WAIT && !sync2_reg |=> core_rst_o)
    else $error("core left reset while pin low");
  // Pin seen high releases the core on the next cycle
  resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_WAIT && sync2_reg |=> !core_rst_o && imask_set_o)
    else $error("no resume after pin high");
  // Software can never raise the power flag
  porflag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !porf_reg && st_reg != RCW_ST_POR |=> !porf_reg)
    else $error("power flag set by software");
  // Once enabled, only a core reset turns the watchdog off
  noff_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wden_reg && !core_rst_o |=> wden_reg)
    else $error("watchdog disabled");
  // A kick returns the counter to zero
  kick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit(RCW_MISC_ADDR) && wb_dat_i[0] |=> wdc_reg == 3'h0)
    else $error("kick did not clear counter");
  // Final state fires a chip reset and pulls the pin
  fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_RUN && wden_reg && wdc_reg == 3'h7 |=> core_rst_o && !pin_rst_oe_n_o)
    else $error("no watchdog reset at final state");
  // Watchdog pulse lasts at least the minimum length
  dogpulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_reg == RCW_ST_DOG) |-> !pin_rst_oe_n_o [*3])
    else $error("watchdog pulse too short");
  // Interrupt follows last cycle's status and mask; reset cycle excluded
  irq_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> irq_o == |($past(ist_next) & $past(imk_next)))
    else $error("interrupt level wrong");
  // Core held in reset throughout the power-on state
  core_por_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_POR |-> core_rst_o)
    else $error("core free during power-on");
  // Delay counter frozen until the oscillator runs
  por_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_POR && !osc_ok_i |=> cnt_reg == $past(cnt_reg))
    else $error("delay counted without oscillator");
  // Last delay count releases the pin
  por_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_POR && osc_ok_i && cnt_reg == POR_CYC - 13'h1
    |=> st_reg == RCW_ST_WAIT && pin_rst_oe_n_o)
    else $error("power-on delay end wrong");
  // Power flag set while in power-on
  porf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_POR |=> porf_reg)
    else $error("power flag not set");
  // Mask-set pulse marks every release
  mask_rel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(core_rst_o) |-> imask_set_o)
    else $error("no mask pulse at release");
  // Mask-set is a single-cycle pulse
  mask_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    imask_set_o |=> !imask_set_o)
    else $error("mask pulse too long");
  // Outside pulls are never driven back by the device
  wait_nodrv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_WAIT |-> pin_rst_oe_n_o)
    else $error("pin pulled while waiting");
  // Running means pin released and core free
  run_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_RUN |-> pin_rst_oe_n_o && !core_rst_o)
    else $error("running state outputs wrong");
  // Second flop only ever copies the first
  sync_chain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> sync2_reg == $past(sync1_reg))
    else $error("synchroniser chain broken");
  // Pin seen low in run starts an outside reset
  ext_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_RUN && !sync2_reg && !wdfire |=> core_rst_o && st_reg == RCW_ST_WAIT)
    else $error("outside reset missed");
  // Outside reset records its cause
  cause_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[RCW_EV_EXT] |=> rs_reg.cause == 2'd1 && ist_reg[RCW_EV_EXT])
    else $error("outside cause not kept");
  // Watchdog reset records its cause; set beats clear
  cause_dog_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[RCW_EV_WATCHDOG_ENABLE_KICK] |=> rs_reg.cause == 2'd2 && ist_reg[RCW_EV_WATCHDOG_ENABLE_KICK])
    else $error("watchdog cause not kept");
  // Core held while the watchdog pulse runs
  dog_core_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_DOG |-> core_rst_o)
    else $error("core free during watchdog pulse");
  // Pin not yet seen low keeps the pulse going
  dog_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_DOG && sync2_reg |=> st_reg == RCW_ST_DOG && !pin_rst_oe_n_o)
    else $error("pulse ended before pin seen low");
  // Pulse ends after the pin was seen low long enough
  dog_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == RCW_ST_DOG && !sync2_reg && cnt_reg == 13'(RCW_DOG_PULSE_CYC) - 13'h1
    |=> st_reg == RCW_ST_WAIT && pin_rst_oe_n_o)
    else $error("pulse not released");
  // Any core reset restores the option and clears the count
  wd_opt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    core_rst_o |=> wden_reg == WATCHDOG_ENABLE_KICK_AUTO && wdc_reg == 3'h0)
    else $error("watchdog not restored");
  // A disabled watchdog never counts
  wd_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wden_reg |=> wdc_reg == 3'h0)
    else $error("disabled watchdog counted");
  // Counter steps only on a timer carry
  wd_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wdc_reg != $past(wdc_reg) && wdc_reg != 3'h0 |-> $past(tmr_carry7_i))
    else $error("counter stepped without carry");
  // Counter steps only when both prescalers wrap
  wd_pre_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wdc_reg != $past(wdc_reg) && wdc_reg != 3'h0
    |-> $past(pre4_reg) == 2'h3 && $past(pre256_reg) == 8'hff)
    else $error("counter stepped off prescale");
  // Acknowledge is a single-cycle pulse
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held");
  // Every request answered on the next cycle
  ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
endmodule : rcw_top
`default_nettype wire

/* File: test/rcw_rst_partner.sv */
// Outside reset circuit: pull-up, open-drain wired-and, timed hold-low pulses
`timescale 1ns/100ps
`default_nettype none
module rcw_rst_partner (
  input  wire logic clk_i,          // Machine clock
  input  wire logic pin_drv_i,      // Device pin value
  input  wire logic pin_oe_n_i,     // Device pulls when low
  input  wire logic hold_req_i,     // Bench asks for a low pulse
  output logic      pin_rst_n_o     // Resolved pin level
);
  logic [1:0] stretch_reg = 2'h0;   // Remaining hold cycles
  // Each request holds the pin at least two full cycles, above the minimum
  always_ff @(posedge clk_i) begin
    if (hold_req_i) begin
      stretch_reg <= 2'h2;
    end else if (stretch_reg != 2'h0) begin
      stretch_reg <= stretch_reg - 2'h1;
    end
  end
  // Pull-up wins only when nobody pulls, so a released pin reads high
  assign pin_rst_n_o = (pin_oe_n_i ? 1'b1 : pin_drv_i)
                     & ~(hold_req_i | (stretch_reg != 2'h0));
endmodule : rcw_rst_partner
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the reset and watchdog block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rcw_pkg::*;
  localparam int POR_CYC = 20;  // Shortened long delay keeps the run brief
  logic        clk_i = 1'b0, rst_i = 1'b1, osc_ok = 1'b1, hold = 1'b0;
  logic        car = 1'b0, car_en = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;     // Bus address
  logic [31:0] dat = 32'h0, q;  // Write data, last read data
  wire         pin_n, pin_o, oe_n, core_rst, imask, irq, ack;
  wire  [15:0] vec;             // Vector address
  wire  [31:0] dat_o;           // Bus read data
  int          bad_count = 0, checked = 0, ncar = 0, nmask = 0;
  // Machine clock
  initial forever #20 clk_i = ~clk_i;
  // Timer carry pulses every other cycle; count carries and mask pulses
  always @(posedge clk_i) begin
    car <= car_en & ~car;
    ncar <= ncar + int'(car);
    nmask <= nmask + int'(imask);
  end
  rcw_top #(.POR_LONG_CYC(POR_CYC), .POR_LONG_SEL(1'b1), .WATCHDOG_ENABLE_KICK_AUTO(1'b0)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .osc_ok_i(osc_ok), .pin_rst_n_i(pin_n),
    .pin_rst_o(pin_o), .pin_rst_oe_n_o(oe_n), .tmr_carry7_i(car),
    .core_rst_o(core_rst), .imask_set_o(imask), .vec_addr_o(vec), .irq_o(irq),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  rcw_rst_partner i_pin (.clk_i(clk_i), .pin_drv_i(pin_o),
    .pin_oe_n_i(oe_n), .hold_req_i(hold), .pin_rst_n_o(pin_n));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic Wishbone cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 20);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 20) chk(32'h0, 32'h1);
  endtask : wb
  // Supply rise then release of the detector
  task pwr_up;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : pwr_up
  // Wait for the core to leave reset, bounded
  task wait_run(output int k);
    k = 0;
    while (core_rst !== 1'b0 && k < 200) begin @(posedge clk_i); k++; end
  endtask : wait_run
  // Power-on delay, pin pull, vector, mask pulse, power flag
  task t_por;
    int k, m;
    m = nmask;
    osc_ok <= 1'b0;
    pwr_up;
    chk(oe_n, 1'b0);
    repeat (5) @(posedge clk_i);
    chk(oe_n, 1'b0);
    osc_ok <= 1'b1;
    k = 0;
    while (oe_n !== 1'b1 && k < 100) begin @(posedge clk_i); k++; end
    chk(k >= POR_CYC - 1 && k <= POR_CYC + 2, 1);
    wait_run(k);
    chk(k <= 5, 1);
    repeat (2) @(posedge clk_i);
    chk(nmask - m, 1);
    chk(vec, RCW_VEC_LO);
    wb(1'b0, RCW_MISC_ADDR, 32'h0);
    chk(q & 32'hff, 32'h80);
    wb(1'b1, RCW_MISC_ADDR, 32'h0);
    wb(1'b1, RCW_MISC_ADDR, 32'h80);
    wb(1'b0, RCW_MISC_ADDR, 32'h0);
    chk(q & 32'hff, 32'h0);
    $display("test power-on done");
  endtask : t_por
  // Pin held low past the delay keeps the core in reset
  task t_hold;
    int k;
    hold <= 1'b1;
    pwr_up;
    repeat (POR_CYC + 10) @(posedge clk_i);
    chk(core_rst, 1'b1);
    hold <= 1'b0;
    wait_run(k);
    chk(k <= 6, 1);
    $display("test held pin done");
  endtask : t_hold
  // Short outside pulse in run, cause, vector, interrupt mask and clear
  task t_ext;
    int k;
    wb(1'b1, RCW_IRQ_MK_ADDR, 32'h0);
    wb(1'b1, RCW_IRQ_ST_ADDR, 32'h7);
    @(posedge clk_i);
    hold <= 1'b1;
    @(posedge clk_i);
    hold <= 1'b0;
    k = 0;
    while (core_rst !== 1'b1 && k < 10) begin @(posedge clk_i); k++; end
    chk(k <= 5, 1);
    wait_run(k);
    chk(k <= 6, 1);
    wb(1'b0, RCW_IRQ_ST_ADDR, 32'h0);
    chk(q & 32'h7, 32'h2);
    wb(1'b0, RCW_VEC_ADDR, 32'h0);
    chk(q & 32'h3ffff, {14'h0, 2'h1, RCW_VEC_LO});
    chk(irq, 1'b0);
    wb(1'b1, RCW_IRQ_MK_ADDR, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b1, RCW_IRQ_ST_ADDR, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    $display("test outside reset done");
  endtask : t_ext
  // Enable, ignored zero write, kick, timeout, pin pulse, option restore
  task t_watchdog_enable_kick;
    int k, base, lim;
    lim = RCW_PRE4 * RCW_PRE256;
    wb(1'b1, RCW_MISC_ADDR, 32'h1);
    wb(1'b1, RCW_MISC_ADDR, 32'h0);
    wb(1'b0, RCW_MISC_ADDR, 32'h0);
    chk(q[0], 1'b1);
    car_en <= 1'b1;
    base = ncar;
    while (ncar - base < 5000) @(posedge clk_i);
    chk(core_rst, 1'b0);
    wb(1'b1, RCW_MISC_ADDR, 32'h1);
    base = ncar;
    while (core_rst !== 1'b1 && ncar - base < 8000) @(posedge clk_i);
    k = ncar - base;
    chk(k > lim * 6 && k <= lim * int'(RCW_WD_FINAL) + 2, 1);
    car_en <= 1'b0;
    k = 0;
    while (oe_n !== 1'b0 && k < 3) begin @(posedge clk_i); k++; end
    k = 0;
    while (oe_n === 1'b0 && k < 50) begin @(posedge clk_i); k++; end
    chk(k >= int'(RCW_DOG_PULSE_CYC) && k < 50, 1);
    wait_run(k);
    wb(1'b0, RCW_IRQ_ST_ADDR, 32'h0);
    chk(q & 32'h4, 32'h4);
    wb(1'b0, RCW_MISC_ADDR, 32'h0);
    chk(q[0], 1'b0);
    $display("test watchdog done");
  endtask : t_watchdog_enable_kick
  // Verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    t_por;
    t_hold;
    t_ext;
    t_watchdog_enable_kick;
    test_done;
  end
  // Hang guard, about two and a half times the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    test_done;
  end
endmodule : tb
`default_nettype wire
